// File: include/tmasc_pkg.sv
package tmasc_pkg;
  // Clock and timing
  localparam int CLK_NS = 4;
  localparam int SCL_HALF_NS = 5000;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_NS = 2000;
  localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int PERIOD_NS = 1000000;
  localparam int PERIOD_CYC = PERIOD_NS / CLK_NS;

  // Bus addresses
  localparam logic [6:0] ARA_ADDR = 7'h0C;
  localparam logic [6:0] DEV_ADDR_DEF = 7'h2A;

  // Read-side pointer values
  localparam logic [7:0] RD_LOCAL_TEMP = 8'h00;
  localparam logic [7:0] RD_REMOTE_TEMP = 8'h01;
  localparam logic [7:0] RD_STATUS = 8'h02;
  localparam logic [7:0] RD_CONFIG = 8'h03;
  localparam logic [7:0] RD_LOCAL_HI = 8'h05;
  localparam logic [7:0] RD_LOCAL_LO = 8'h06;
  localparam logic [7:0] RD_REMOTE_HI = 8'h07;
  localparam logic [7:0] RD_REMOTE_LO = 8'h08;
  localparam logic [7:0] RD_REMOTE_FRAC = 8'h10;
  // Write-side pointer values
  localparam logic [7:0] WR_CONFIG = 8'h09;
  localparam logic [7:0] WR_LOCAL_HI = 8'h0B;
  localparam logic [7:0] WR_LOCAL_LO = 8'h0C;
  localparam logic [7:0] WR_REMOTE_HI = 8'h0D;
  localparam logic [7:0] WR_REMOTE_LO = 8'h0E;
  localparam logic [7:0] WR_ONE_SHOT = 8'h0F;

  // Field positions and reset values
  localparam int CFG_STANDBY_BIT = 6;
  localparam int STAT_LOCAL_HI_BIT = 6;
  localparam int STAT_LOCAL_LO_BIT = 5;
  localparam int STAT_REMOTE_HI_BIT = 4;
  localparam int STAT_REMOTE_LO_BIT = 3;
  localparam int STAT_OPEN_BIT = 2;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] LIM_HI_RST = 8'h7F;
  localparam logic [7:0] LIM_LO_RST = 8'h80;
  localparam logic [7:0] UNMAPPED_RD = 8'hFF;
  localparam logic [10:0] REMOTE_FLOOR = 11'h400;

  // Host controller APB map
  localparam logic [7:0] HREG_CMD = 8'h00;
  localparam logic [7:0] HREG_CTRL = 8'h04;
  localparam logic [7:0] HREG_STAT = 8'h08;
  localparam logic [1:0] OP_PTR = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ARA = 2'h3;
  localparam int CMD_PTR_LSB = 8;
  localparam int CMD_DATA_LSB = 16;
  localparam int CTRL_AUTO_BIT = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;
  localparam int STAT_ALERT_BIT = 2;
  localparam int STAT_RX_LSB = 8;
  localparam int STAT_ARA_LSB = 16;
endpackage

// File: include/tmasc_if.sv
interface tmasc_if;
  logic scl_o;
  logic scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic alert_o;
  logic alert_oe;
  logic scl;
  logic sda;
  logic alert_n;

  // Open-drain resolution: released lines read high
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);
  assign alert_n = alert_oe ? alert_o : 1'b1;

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe,
               output alert_o, output alert_oe);
  modport host (input scl, input sda, input alert_n, output scl_o, output scl_oe,
                output host_sda_o, output host_sda_oe);
endinterface

// File: rtl/tmasc_device.sv
// Operation
// - first written byte always loads pointer
// - read returns register selected by pointer
// - read and write pointers differ
// - alert low on limit or open fault
// - alert pin is open-drain, wired-AND
// - asserting device answers ARA with address
// - bit arbitration decides ARA, lowest wins
// - release alert after ARA if cleared
// - host repeats ARA while line low
// - standby on pin low or config bit
// - standby aborts conversion, no result write
// - serial slave works during standby
// - pin standby blocks all conversions
// - one-shot write in software standby starts one conversion
// - sample open comparator at conversion start
// - shorted remote reports minus 128 code
// - host sets remote low limit 80h
// - one-shot does one cycle, byte dropped
// - strict greater/less limit comparisons
module tmasc_device #(
  parameter logic [6:0] DEV_ADDR = tmasc_pkg::DEV_ADDR_DEF,
  parameter int CONV_PERIOD_CYC = tmasc_pkg::PERIOD_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  tmasc_if.dev bus,
  input wire logic sleep_request_pin_n,
  input wire logic open_comp,
  input wire logic [7:0] local_meas,
  input wire logic [10:0] remote_meas,
  input wire logic remote_under,
  output logic adc_start,
  output logic conv_busy
);
  typedef enum logic [1:0] {S_IDLE, S_ADDR, S_WRITE, S_READ} tmasc_slv_e;
  typedef enum logic {C_IDLE, C_RUN} tmasc_conv_e;

  logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3, slp_s1, slp_s2;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  tmasc_slv_e st;
  logic [3:0] bitcnt;
  logic [7:0] sh, tx, ptr, wr_data, rd_byte, tx_next;
  logic got_rise, first, wr_stb, ara_cyc, ara_done, rd_nack, sda_oe;
  logic [7:0] cfg, lhi, llo, rhi, rlo, status, local_temp;
  logic [10:0] remote_temp;
  logic os_req, alert_q, open_lat, single, hw_sleep_request_pin_n, standby, cond_now;
  tmasc_conv_e cst;
  logic [31:0] cnt, period_cnt;
  logic conv_go, abort;

  // Pins from the far side pass two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {scl_s1, scl_s2, scl_s3} <= 3'h7;
      {sda_s1, sda_s2, sda_s3} <= 3'h7;
      {slp_s1, slp_s2} <= 2'h3;
    end else begin
      {scl_s1, scl_s2, scl_s3} <= {bus.scl, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_s3} <= {bus.sda, sda_s1, sda_s2};
      {slp_s1, slp_s2} <= {sleep_request_pin_n, slp_s1};
    end
  end

  // Edges and bus conditions from the second and third stages
  assign scl_rise = scl_s2 && !scl_s3;
  assign scl_fall = !scl_s2 && scl_s3;
  assign start_cond = scl_s2 && scl_s3 && !sda_s2 && sda_s3;
  assign stop_cond = scl_s2 && scl_s3 && sda_s2 && !sda_s3;
  assign hw_sleep_request_pin_n = !slp_s2;
  assign standby = hw_sleep_request_pin_n || cfg[tmasc_pkg::CFG_STANDBY_BIT];

  // Read mux; write-side pointers return filler, not contents
  always_comb begin
    case (ptr)
      tmasc_pkg::RD_LOCAL_TEMP: rd_byte = local_temp;
      tmasc_pkg::RD_REMOTE_TEMP: rd_byte = remote_temp[10:3];
      tmasc_pkg::RD_REMOTE_FRAC: rd_byte = {remote_temp[2:0], 5'h00};
      tmasc_pkg::RD_STATUS: rd_byte = status;
      tmasc_pkg::RD_CONFIG: rd_byte = cfg;
      tmasc_pkg::RD_LOCAL_HI: rd_byte = lhi;
      tmasc_pkg::RD_LOCAL_LO: rd_byte = llo;
      tmasc_pkg::RD_REMOTE_HI: rd_byte = rhi;
      tmasc_pkg::RD_REMOTE_LO: rd_byte = rlo;
      default: rd_byte = tmasc_pkg::UNMAPPED_RD;
    endcase
    tx_next = ara_cyc ? {DEV_ADDR, 1'b0} : rd_byte;
  end

  // Serial slave; no standby term, so it runs in every mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= S_IDLE;
      bitcnt <= 4'h0;
      sh <= 8'h00;
      tx <= 8'h00;
      ptr <= 8'h00;
      wr_data <= 8'h00;
      {sda_oe, got_rise, first, wr_stb, ara_cyc, ara_done, rd_nack} <= 7'h00;
    end else begin
      wr_stb <= 1'b0;
      ara_done <= 1'b0;
      if (start_cond) begin
        st <= S_ADDR;
        bitcnt <= 4'h0;
        got_rise <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop_cond) begin
        st <= S_IDLE;
        sda_oe <= 1'b0;
      end else if (st != S_IDLE && scl_rise) begin
        got_rise <= 1'b1;
        if (bitcnt == 4'h8) begin
          rd_nack <= sda_s2;
        end else if (st == S_READ) begin
          if (tx[7] && !sda_s2) begin
            st <= S_IDLE;
            ara_cyc <= 1'b0;
          end
        end else begin
          sh <= {sh[6:0], sda_s2};
        end
      end else if (st != S_IDLE && scl_fall && got_rise) begin
        got_rise <= 1'b0;
        if (bitcnt == 4'h7) begin
          bitcnt <= 4'h8;
          case (st)
            S_ADDR: begin
              if (sh[7:1] == DEV_ADDR || (sh[7:1] == tmasc_pkg::ARA_ADDR && sh[0] && alert_q)) begin
                sda_oe <= 1'b1;
                ara_cyc <= sh[7:1] == tmasc_pkg::ARA_ADDR;
                first <= 1'b1;
              end else begin
                st <= S_IDLE;
              end
            end
            S_WRITE: begin
              sda_oe <= 1'b1;
              first <= 1'b0;
              if (first) begin
                ptr <= sh;
              end else begin
                wr_stb <= 1'b1;
                wr_data <= sh;
              end
            end
            default: sda_oe <= 1'b0; // Let the host ack or nack
          endcase
        end else if (bitcnt == 4'h8) begin
          bitcnt <= 4'h0;
          case (st)
            S_ADDR: begin
              if (sh[0]) begin
                st <= S_READ;
                tx <= tx_next;
                sda_oe <= !tx_next[7];
              end else begin
                st <= S_WRITE;
                sda_oe <= 1'b0;
              end
            end
            S_WRITE: sda_oe <= 1'b0;
            default: begin
              ara_done <= ara_cyc;
              ara_cyc <= 1'b0;
              if (rd_nack) begin
                st <= S_IDLE;
                sda_oe <= 1'b0;
              end else begin
                tx <= tx_next;
                sda_oe <= !tx_next[7];
              end
            end
          endcase
        end else begin
          bitcnt <= 4'(bitcnt + 4'h1);
          if (st == S_READ) begin
            tx <= {tx[6:0], 1'b0};
            sda_oe <= !tx[6];
          end
        end
      end
      if (st == S_IDLE || start_cond || stop_cond) begin
        sda_oe <= 1'b0; // Never hold SDA after losing or leaving
      end
    end
  end

  // Writable registers; one-shot byte is never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= tmasc_pkg::CFG_RST;
      lhi <= tmasc_pkg::LIM_HI_RST;
      llo <= tmasc_pkg::LIM_LO_RST;
      rhi <= tmasc_pkg::LIM_HI_RST;
      rlo <= tmasc_pkg::LIM_LO_RST;
      os_req <= 1'b0;
    end else begin
      if (conv_go) begin
        os_req <= 1'b0;
      end
      if (wr_stb) begin
        case (ptr)
          tmasc_pkg::WR_CONFIG: cfg <= wr_data;
          tmasc_pkg::WR_LOCAL_HI: lhi <= wr_data;
          tmasc_pkg::WR_LOCAL_LO: llo <= wr_data;
          tmasc_pkg::WR_REMOTE_HI: rhi <= wr_data;
          tmasc_pkg::WR_REMOTE_LO: rlo <= wr_data;
          tmasc_pkg::WR_ONE_SHOT: begin
            if (cfg[tmasc_pkg::CFG_STANDBY_BIT] && !hw_sleep_request_pin_n) begin
              os_req <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Start and abort terms for the converter
  assign conv_go = cst == C_IDLE && !hw_sleep_request_pin_n && (os_req || (!standby && period_cnt == 32'h0));
  assign abort = hw_sleep_request_pin_n || (cfg[tmasc_pkg::CFG_STANDBY_BIT] && !single);
  assign cond_now = |status;

  // Conversion sequencer, results, status and alert
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cst <= C_IDLE;
      cnt <= 32'h0;
      period_cnt <= 32'h0;
      local_temp <= 8'h00;
      remote_temp <= 11'h000;
      status <= 8'h00;
      {alert_q, open_lat, single, adc_start, conv_busy} <= 5'h00;
    end else begin
      adc_start <= 1'b0;
      if (ara_done && !cond_now) begin
        alert_q <= 1'b0;
      end
      if (!standby && period_cnt != 32'h0) begin
        period_cnt <= period_cnt - 32'h1;
      end
      case (cst)
        C_IDLE: begin
          if (conv_go) begin
            cst <= C_RUN;
            cnt <= 32'(tmasc_pkg::CONV_CYC - 1);
            period_cnt <= 32'(CONV_PERIOD_CYC - 1);
            single <= standby;
            open_lat <= open_comp;
            adc_start <= 1'b1;
            conv_busy <= 1'b1;
          end
        end
        C_RUN: begin
          if (abort) begin
            cst <= C_IDLE;
            conv_busy <= 1'b0;
          end else if (cnt != 32'h0) begin
            cnt <= cnt - 32'h1;
          end else begin
            cst <= C_IDLE;
            conv_busy <= 1'b0;
            local_temp <= local_meas;
            remote_temp <= remote_under ? tmasc_pkg::REMOTE_FLOOR : remote_meas;
            status <= 8'h00;
            status[tmasc_pkg::STAT_OPEN_BIT] <= open_lat;
            status[tmasc_pkg::STAT_LOCAL_HI_BIT] <= $signed(local_meas) > $signed(lhi);
            status[tmasc_pkg::STAT_LOCAL_LO_BIT] <= $signed(local_meas) < $signed(llo);
            if (remote_under) begin
              status[tmasc_pkg::STAT_REMOTE_HI_BIT] <= 1'b0;
              status[tmasc_pkg::STAT_REMOTE_LO_BIT] <=
                $signed(tmasc_pkg::REMOTE_FLOOR[10:3]) < $signed(rlo);
            end else begin
              status[tmasc_pkg::STAT_REMOTE_HI_BIT] <= $signed(remote_meas[10:3]) > $signed(rhi);
              status[tmasc_pkg::STAT_REMOTE_LO_BIT] <= $signed(remote_meas[10:3]) < $signed(rlo);
            end
            // Set after the release so a fresh fault wins
            alert_q <= open_lat || $signed(local_meas) > $signed(lhi) ||
                       $signed(local_meas) < $signed(llo) ||
                       (!remote_under && $signed(remote_meas[10:3]) > $signed(rhi)) ||
                       $signed(remote_under ? tmasc_pkg::REMOTE_FLOOR[10:3] : remote_meas[10:3])
                         < $signed(rlo);
          end
        end
        default: cst <= C_IDLE;
      endcase
    end
  end

  // Open-drain pins: only ever pull low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus.dev_sda_o <= 1'b0;
      bus.dev_sda_oe <= 1'b0;
      bus.alert_o <= 1'b0;
      bus.alert_oe <= 1'b0;
    end else begin
      bus.dev_sda_o <= 1'b0;
      bus.dev_sda_oe <= sda_oe;
      bus.alert_o <= 1'b0;
      bus.alert_oe <= alert_q;
    end
  end
endmodule // tmasc_device

// File: rtl/tmasc_host.sv
module tmasc_host #(
  parameter int HALF_CYC = tmasc_pkg::SCL_HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  tmasc_if.host bus
);
  typedef enum logic [2:0] {H_IDLE, H_START, H_LOW, H_HIGH, H_STOP1, H_STOP2} tmasc_hst_e;

  tmasc_hst_e hs;
  logic sda_s1, sda_s2, al_s1, al_s2;
  logic [1:0] op;
  logic [7:0] cptr, cdata, sh, rx;
  logic [6:0] slv_addr, ara_addr;
  logic auto_ara, busy, nack, go, rd_mode, scl_oe, sda_oe, mapped;
  logic [1:0] byte_idx, last_idx;
  logic [3:0] bitn;
  logic [15:0] tick;
  logic tick_end, tick_mid, launch, ack_bad, auto_run;

  // Far-side pins pass two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {sda_s1, sda_s2, al_s1, al_s2} <= 4'hF;
    end else begin
      {sda_s1, sda_s2} <= {bus.sda, sda_s1};
      {al_s1, al_s2} <= {bus.alert_n, al_s1};
    end
  end

  assign mapped = paddr == tmasc_pkg::HREG_CMD || paddr == tmasc_pkg::HREG_CTRL ||
                  paddr == tmasc_pkg::HREG_STAT;

  // APB slave: one wait state, write lands on the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      {op, cptr, cdata} <= 18'h0;
      slv_addr <= tmasc_pkg::DEV_ADDR_DEF;
      auto_ara <= 1'b0;
      go <= 1'b0;
    end else begin
      go <= 1'b0;
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        pslverr <= !mapped;
        case (paddr)
          tmasc_pkg::HREG_CMD: prdata <= {8'h00, cdata, cptr, 6'h00, op};
          tmasc_pkg::HREG_CTRL: prdata <= {23'h0, auto_ara, 1'b0, slv_addr};
          tmasc_pkg::HREG_STAT:
            prdata <= {9'h0, ara_addr, rx, 5'h00, !al_s2, nack, busy};
          default: prdata <= 32'h0;
        endcase
      end
      if (psel && penable && pready && pwrite) begin
        if (paddr == tmasc_pkg::HREG_CMD && !busy) begin
          op <= pwdata[1:0];
          cptr <= pwdata[tmasc_pkg::CMD_PTR_LSB +: 8];
          cdata <= pwdata[tmasc_pkg::CMD_DATA_LSB +: 8];
          go <= 1'b1; // Ignored while a transfer is under way
        end
        if (paddr == tmasc_pkg::HREG_CTRL) begin
          slv_addr <= pwdata[6:0];
          auto_ara <= pwdata[tmasc_pkg::CTRL_AUTO_BIT];
        end
      end
    end
  end

  // Line low with auto mode keeps issuing alert reads
  assign launch = hs == H_IDLE && !go && (busy || (auto_ara && !al_s2));
  assign tick_end = tick == 16'(HALF_CYC - 1);
  assign tick_mid = tick == 16'(HALF_CYC / 2);
  assign ack_bad = !(rd_mode && byte_idx != 2'h0) && sda_s2;

  // Bit engine: address byte, then pointer, data or one read byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs <= H_IDLE;
      {auto_run, busy, nack, rd_mode, scl_oe, sda_oe} <= 6'h00;
      {byte_idx, last_idx, bitn} <= 8'h00;
      tick <= 16'h0;
      {sh, rx} <= 16'h0;
      ara_addr <= 7'h00;
    end else begin
      tick <= (tick_end || hs == H_IDLE) ? 16'h0 : 16'(tick + 16'h1);
      if (go) begin
        busy <= 1'b1;
      end
      case (hs)
        H_IDLE: begin
          if (launch) begin
            busy <= 1'b1;
            auto_run <= !busy; // Busy rises here, so remember who launched
            hs <= H_START;
            sda_oe <= 1'b1;
            byte_idx <= 2'h0;
            bitn <= 4'h0;
            nack <= 1'b0;
            rd_mode <= !busy || op[1];
            if (!busy || op == tmasc_pkg::OP_ARA) begin
              sh <= {tmasc_pkg::ARA_ADDR, 1'b1};
            end else begin
              sh <= {slv_addr, op[1]};
            end
            last_idx <= (busy && op == tmasc_pkg::OP_WRITE) ? 2'h2 : 2'h1;
          end
        end
        H_START: if (tick_end) begin
          scl_oe <= 1'b1;
          hs <= H_LOW;
        end
        H_LOW: begin
          if (tick_mid) begin
            sda_oe <= (bitn == 4'h8 || (rd_mode && byte_idx != 2'h0)) ? 1'b0 : !sh[7];
          end
          if (tick_end) begin
            scl_oe <= 1'b0;
            hs <= H_HIGH;
          end
        end
        H_HIGH: if (tick_end) begin
          scl_oe <= 1'b1;
          hs <= H_LOW;
          if (bitn != 4'h8) begin
            sh <= {sh[6:0], sda_s2};
            bitn <= 4'(bitn + 4'h1);
          end else if (ack_bad || byte_idx == last_idx) begin
            nack <= ack_bad;
            hs <= H_STOP1;
          end else begin
            byte_idx <= 2'(byte_idx + 2'h1);
            sh <= byte_idx == 2'h0 ? cptr : cdata;
            bitn <= 4'h0;
          end
        end
        H_STOP1: begin
          if (tick_mid) begin
            sda_oe <= 1'b1;
          end
          if (tick_end) begin
            scl_oe <= 1'b0;
            hs <= H_STOP2;
          end
        end
        H_STOP2: if (tick_end) begin
          sda_oe <= 1'b0;
          hs <= H_IDLE;
          busy <= 1'b0;
          if (rd_mode && !nack) begin
            rx <= sh;
            if (sh[0] == 1'b0 && (op == tmasc_pkg::OP_ARA || auto_run)) begin
              ara_addr <= sh[7:1];
            end
          end
        end
        default: hs <= H_IDLE;
      endcase
    end
  end

  // Open-drain pins: only ever pull low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {bus.scl_o, bus.scl_oe, bus.host_sda_o, bus.host_sda_oe} <= 4'h0;
    end else begin
      bus.scl_o <= 1'b0;
      bus.scl_oe <= scl_oe;
      bus.host_sda_o <= 1'b0;
      bus.host_sda_oe <= sda_oe;
    end
  end
endmodule // tmasc_host

// File: bench/tmasc_properties.sv
module tmasc_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic alert_o,
  input wire logic alert_oe,
  input wire logic alert_n,
  input wire logic adc_start,
  input wire logic conv_busy,
  input wire logic sleep_request_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CLO = tmasc_pkg::CONV_CYC - 3;
  localparam int CHI = tmasc_pkg::CONV_CYC + 3;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  int since;
  int low;
  // Cycles since the last start; loose window absorbs the result pipeline
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since <= 0;
    else since <= adc_start ? 0 : since + 1;
  end
  // Cycles the standby pin has been low, synchronizer delay allowed for
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low <= 0;
    else low <= sleep_request_pin_n ? 0 : low + 1;
  end
  sequence s_run;
    conv_busy [*4];
  endsequence
  sequence s_result;
    since >= CLO && since <= CHI;
  endsequence
  a_alert_open_drain: assert property (alert_oe |-> !alert_o && !alert_n)
    else $error("alert driven high or line not low");
  a_sda_open_drain: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("device drives data line high");
  a_sda_scl_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device data changed while clock high");
  a_alert_at_result: assert property ($rose(alert_oe) |-> s_result)
    else $error("alert asserted away from a conversion result");
  // Start cycle skipped: the counter only restarts one edge after the pulse
  a_busy_bounded: assert property (conv_busy && !adc_start |-> since <= CHI)
    else $error("conversion runs too long");
  a_pin_blocks: assert property (low > 4 |-> !adc_start)
    else $error("conversion started with standby pin low");
  a_start_idle: assert property (adc_start |-> !$past(conv_busy))
    else $error("conversion started while one runs");
  a_start_runs: assert property (adc_start |-> ##[0:1] s_run)
    else $error("start without a running conversion");
endmodule // tmasc_properties

// File: bench/tb_temp_monitor_alert_standby_ctrl.sv
module tb_temp_monitor_alert_standby_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic sleep_request_pin_n, open_comp, remote_under, adc_start, conv_busy;
  logic [7:0] paddr, m, local_meas;
  logic [10:0] remote_meas;
  logic [31:0] pwdata, prdata, r, rnd;
  logic [32:0] exp_q[$], msk_q[$];
  int miscompares = 0;
  int n_tests = 0;
  int seed = 32'hEE96;
  tmasc_if bus_if();
  tmasc_host #(.HALF_CYC(20)) tmasc_host_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus(bus_if.host));
  tmasc_device #(.CONV_PERIOD_CYC(2000)) tmasc_device_i (.pclk(pclk), .presetn(presetn),
    .bus(bus_if.dev), .sleep_request_pin_n(sleep_request_pin_n), .open_comp(open_comp),
    .local_meas(local_meas), .remote_meas(remote_meas), .remote_under(remote_under),
    .adc_start(adc_start), .conv_busy(conv_busy));
  tmasc_properties tmasc_properties_i (.pclk(pclk), .presetn(presetn), .scl(bus_if.scl),
    .dev_sda_o(bus_if.dev_sda_o), .dev_sda_oe(bus_if.dev_sda_oe), .alert_o(bus_if.alert_o),
    .alert_oe(bus_if.alert_oe), .alert_n(bus_if.alert_n), .adc_start(adc_start),
    .conv_busy(conv_busy), .sleep_request_pin_n(sleep_request_pin_n));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic tally_and_finish();
    $display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [32:0] got, input logic [32:0] e, input logic [32:0] k);
    n_tests++;
    if (((got ^ e) & k) !== 33'h0) begin
      miscompares++;
      $display("[ERR] %0t read %h expected %h", $time, got, e);
    end
  endtask
  // Monitor: each completed read with a pending note is checked
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() != 0)
      cmp({pslverr, prdata}, exp_q.pop_front(), msk_q.pop_front());
  end
  // One transfer; request held until pready seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) miscompares++;
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] k);
    exp_q.push_back(e);
    msk_q.push_back(k);
    apb(1'b0, a, 32'h0);
  endtask
  // Start a bus operation and poll until the controller is idle
  task automatic smb(input logic [1:0] op, input logic [7:0] p, input logic [7:0] d);
    int n;
    n = 0;
    apb(1'b1, tmasc_pkg::HREG_CMD, {8'h00, d, p, 6'h00, op});
    do apb(1'b0, tmasc_pkg::HREG_STAT, 32'h0); while (r[0] !== 1'b0 && ++n < 1000);
    if (n >= 1000) miscompares++;
  endtask
  task automatic dread(input logic [7:0] p, input logic [7:0] e, input logic setp);
    if (setp) smb(tmasc_pkg::OP_PTR, p, 8'h00);
    smb(tmasc_pkg::OP_READ, 8'h00, 8'h00);
    rd(tmasc_pkg::HREG_STAT, {17'h0, e, 8'h00}, 33'h1_0000_FF02);
  endtask
  // One-shot with a random byte, then wait out one conversion
  task automatic shot();
    rnd = $random(seed);
    smb(tmasc_pkg::OP_WRITE, tmasc_pkg::WR_ONE_SHOT, rnd[7:0]);
    repeat (600) @(posedge pclk);
  endtask
  initial begin
    repeat (80000) @(posedge pclk);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sleep_request_pin_n = 1'b1;
    open_comp = 1'b0;
    local_meas = 8'h10;
    remote_meas = 11'h000;
    remote_under = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    // Unmapped host address, then reset config through the link
    rd(8'h0C, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
    dread(tmasc_pkg::RD_CONFIG, tmasc_pkg::CFG_RST, 1'b1);
    // Software standby; write-side pointer reads nothing back
    smb(tmasc_pkg::OP_WRITE, tmasc_pkg::WR_CONFIG, 8'h40);
    dread(tmasc_pkg::RD_CONFIG, 8'h40, 1'b1);
    dread(tmasc_pkg::WR_CONFIG, tmasc_pkg::UNMAPPED_RD, 1'b1);
    // Equal to high limit passes, one above trips
    rnd = $random(seed);
    m = {2'b00, rnd[5:0]};
    smb(tmasc_pkg::OP_WRITE, tmasc_pkg::WR_LOCAL_HI, m);
    local_meas <= m;
    shot();
    dread(tmasc_pkg::RD_STATUS, 8'h00, 1'b1);
    local_meas <= m + 8'h01;
    shot();
    dread(tmasc_pkg::RD_STATUS, 8'h40, 1'b1);
    dread(tmasc_pkg::RD_STATUS, 8'h40, 1'b0);
    rd(tmasc_pkg::HREG_STAT, 33'h4, 33'h4);
    // Alert response gives own address; fault remains so alert stays
    smb(tmasc_pkg::OP_ARA, 8'h00, 8'h00);
    rd(tmasc_pkg::HREG_STAT, {10'h0, tmasc_pkg::DEV_ADDR_DEF, 16'h0004}, 33'h1_007F_0006);
    // Pin standby blocks the one-shot; old result survives
    local_meas <= m;
    sleep_request_pin_n <= 1'b0;
    shot();
    dread(tmasc_pkg::RD_STATUS, 8'h40, 1'b1);
    sleep_request_pin_n <= 1'b1;
    shot();
    rd(tmasc_pkg::HREG_STAT, 33'h0, 33'h4);
    // Shorted remote reads floor code; open diode flags status
    remote_under <= 1'b1;
    open_comp <= 1'b1;
    smb(tmasc_pkg::OP_WRITE, tmasc_pkg::WR_REMOTE_LO, 8'h00);
    shot();
    dread(tmasc_pkg::RD_STATUS, 8'h0C, 1'b1);
    // Floor code as low limit removes the remote low flag
    smb(tmasc_pkg::OP_WRITE, tmasc_pkg::WR_REMOTE_LO, 8'h80);
    shot();
    dread(tmasc_pkg::RD_REMOTE_TEMP, 8'h80, 1'b1);
    dread(tmasc_pkg::RD_STATUS, 8'h04, 1'b1);
    rd(tmasc_pkg::HREG_STAT, 33'h4, 33'h4);
    // Wrong slave address is not acknowledged
    apb(1'b1, tmasc_pkg::HREG_CTRL, 32'h2B);
    smb(tmasc_pkg::OP_READ, 8'h00, 8'h00);
    rd(tmasc_pkg::HREG_STAT, 33'h2, 33'h1_0000_0002);
    // Back to normal mode: periodic conversion clears the alert
    apb(1'b1, tmasc_pkg::HREG_CTRL, 32'h2A);
    remote_under <= 1'b0;
    open_comp <= 1'b0;
    smb(tmasc_pkg::OP_WRITE, tmasc_pkg::WR_CONFIG, 8'h00);
    repeat (2600) @(posedge pclk);
    rd(tmasc_pkg::HREG_STAT, 33'h0, 33'h4);
    tally_and_finish();
  end
endmodule // tb_temp_monitor_alert_standby_ctrl
